/* File: iwt_target.sv */
`timescale 1ns/1ps
// ****************************************************************
// Byte FIFO between the bus receiver and the code output.
// ****************************************************************
module iwt_fifo #(
   parameter int WIDTH = 8,                 // Word width.
   parameter int DEPTH = 32                 // Word count, a power of two.
) (
   input  wire logic             clk,       // Local clock.
   input  wire logic             rst_n,     // Asynchronous reset, active low.
   input  wire logic [WIDTH-1:0] in_data,   // Word to store.
   input  wire logic             in_valid,  // Word offered.
   output logic                  in_ready,  // Room for a word.
   output logic      [WIDTH-1:0] out_data,  // Oldest word.
   output logic                  out_valid, // A word is held.
   input  wire logic             out_ready  // Drain takes the word.
);
   localparam int AW = $clog2(DEPTH);

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
      $error("iwt_fifo: DEPTH must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];  // Storage.
   logic [AW:0]      wr_ptr;       // Write pointer with wrap bit.
   logic [AW:0]      rd_ptr;       // Read pointer with wrap bit.
   wire              push = in_valid & in_ready;
   wire              pop  = out_valid & out_ready;

   // Full when pointers differ only in the wrap bit; empty when equal.
   assign in_ready  = (wr_ptr ^ {1'b1, {AW{1'b0}}}) != rd_ptr;
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data  = mem[rd_ptr[AW-1:0]];

   // Storage has no reset; only the pointers decide what is valid.
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointers advance on each accepted push and pop.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= wr_ptr + (AW+1)'(push);
         rd_ptr <= rd_ptr + (AW+1)'(pop);
      end
   end
endmodule // iwt_fifo

// ****************************************************************
// Write-only bus target; received bytes with the gate bit clear become current codes.
// ****************************************************************
module iwt_target #(
   parameter int FIFO_DEPTH = 32                        // Bytes buffered before refusal.
) (
   input  wire logic                           clk,        // 100 MHz local clock.
   input  wire logic                           rst_n,      // Asynchronous reset, active low.
   iwt_bus_if.target                           bus,        // Two-wire bus.
   output logic      [iwt_pkg::CODE_BITS-1:0]  code,       // Accepted current code.
   output logic                                code_valid, // Code waiting to be taken.
   input  wire logic                           code_ready, // User takes the code.
   output logic                                selected    // Addressed for writing.
);
   typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_ACK, ST_SKIP} iwt_tstate_t;

   iwt_tstate_t state;          // Receiver state.
   logic [3:0]  bit_cnt;        // Rising clock edges seen in this byte.
   logic [7:0]  shreg;          // Incoming byte, MSB first.
   logic        scl_meta;       // Clock synchroniser, first stage.
   logic        scl_sync;       // Clock synchroniser, second stage.
   logic        scl_prev;       // Clock one cycle before.
   logic        sda_meta;       // Data synchroniser, first stage.
   logic        sda_sync;       // Data synchroniser, second stage.
   logic        sda_prev;       // Data one cycle before.
   logic        fifo_push;      // Byte offered to the FIFO.
   logic [7:0]  fifo_q;         // Oldest stored byte.
   logic        fifo_has;       // FIFO not empty.
   logic        fifo_room;      // FIFO not full.
   logic        fifo_pop;       // FIFO word consumed.

   // ****************************************************************
   // Line sampling and condition decode.
   // ****************************************************************
   // Both lines cross two flops; edges are found on the second and third.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {scl_meta, scl_sync, scl_prev} <= 3'b111;
         {sda_meta, sda_sync, sda_prev} <= 3'b111;
      end else begin
         {scl_meta, scl_sync, scl_prev} <= {bus.scl, scl_meta, scl_sync};
         {sda_meta, sda_sync, sda_prev} <= {bus.sda, sda_meta, sda_sync};
      end
   end

   wire scl_high   = scl_sync & scl_prev;
   wire start_seen = scl_high & sda_prev & ~sda_sync;
   wire stop_seen  = scl_high & ~sda_prev & sda_sync;
   wire scl_rise   = scl_sync & ~scl_prev;
   wire scl_fall   = ~scl_sync & scl_prev;
   wire byte_done  = scl_fall && bit_cnt == 4'(iwt_pkg::BYTE_BITS);
   wire addr_ok    = shreg[7:1] == iwt_pkg::TARGET_ADDR;
   wire dir_ok     = shreg[0] == iwt_pkg::DIR_WRITE;

   // ****************************************************************
   // Receiver state machine.
   // ****************************************************************
   // Start and stop override any state, so a broken byte never wedges us.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state   <= ST_IDLE;
         bit_cnt <= iwt_pkg::BIT_CNT_RST;
         shreg   <= iwt_pkg::BYTE_RST;
      end else if (start_seen) begin
         state   <= ST_ADDR;
         bit_cnt <= iwt_pkg::BIT_CNT_RST;
      end else if (stop_seen) begin
         state   <= ST_IDLE;
      end else begin
         unique case (state)
            ST_IDLE, ST_SKIP: begin
               // Waiting for the next start; the bus is ignored.
            end
            ST_ADDR, ST_DATA: begin
               if (scl_rise && bit_cnt < 4'(iwt_pkg::BYTE_BITS)) begin
                  // Sample while the clock is high, where data is stable.
                  shreg   <= {shreg[6:0], sda_sync};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  if (state == ST_ADDR) begin
                     state <= (addr_ok && dir_ok) ? ST_ACK : ST_SKIP;
                  end else begin
                     // A full FIFO refuses the byte, since this end cannot stretch.
                     state <= fifo_room ? ST_ACK : ST_SKIP;
                  end
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  state   <= ST_DATA;
                  bit_cnt <= iwt_pkg::BIT_CNT_RST;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Pin drive and byte hand-off.
   // ****************************************************************
   // Data is pulled low only for the acknowledge slot; otherwise released.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bus.tgt_sda_oe_n <= 1'b1;
         bus.tgt_sda_o    <= 1'b0;
         fifo_push        <= 1'b0;
         selected         <= 1'b0;
      end else begin
         bus.tgt_sda_o    <= 1'b0;
         bus.tgt_sda_oe_n <= !(state == ST_ACK && !start_seen && !stop_seen && !scl_fall);
         if ((state == ST_ADDR || state == ST_DATA) && byte_done && !start_seen
             && !stop_seen) begin
            bus.tgt_sda_oe_n <= (state == ST_ADDR) ? !(addr_ok && dir_ok) : !fifo_room;
         end
         fifo_push <= state == ST_DATA && byte_done && fifo_room && !start_seen && !stop_seen;
         selected  <= state == ST_DATA || state == ST_ACK;
      end
   end

   iwt_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_data   (shreg),
      .in_valid  (fifo_push),
      .in_ready  (fifo_room),
      .out_data  (fifo_q),
      .out_valid (fifo_has),
      .out_ready (fifo_pop)
   );

   // ****************************************************************
   // Code output stage.
   // ****************************************************************
   // Gated bytes are dropped at once; good ones wait for the user.
   wire gate_set  = fifo_q[iwt_pkg::GATE_BIT];
   wire out_free  = !code_valid || code_ready;
   assign fifo_pop = fifo_has && (gate_set || out_free);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code       <= '0;
         code_valid <= 1'b0;
      end else if (out_free) begin
         code_valid <= fifo_has && !gate_set;
         if (fifo_has && !gate_set) begin
            code <= fifo_q[iwt_pkg::CODE_BITS-1:0];
         end
      end
   end
endmodule // iwt_target

/* File: iwt_pkg.sv */
package iwt_pkg;

   // ****************************************************************
   // Frame layout.
   // ****************************************************************
   localparam int          BYTE_BITS   = 8;            // Bits per byte on the wire.
   localparam int          ACK_BIT_IDX = 8;            // Index of the ninth pulse.
   localparam logic [6:0]  TARGET_ADDR = 7'h75;        // Target address 1110101.
   localparam logic        DIR_WRITE   = 1'b0;         // Direction bit value for write.
   localparam int          GATE_BIT    = 7;            // Position of current_update_gate_bit.
   localparam int          CODE_BITS   = 7;            // Width of a current code.

   // ****************************************************************
   // Timing of the controller's own clock divider.
   // ****************************************************************
   localparam int          CLK_PERIOD_NS = 10;         // Local clock period.
   localparam int          SCL_LOW_NS    = 4700;       // Least clock low time.
   localparam int          SCL_HIGH_NS   = 4000;       // Least clock high time.
   localparam int          BUS_FREE_NS   = 4700;       // Least gap from stop to start.
   localparam int          SCL_LOW_CYC   = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          SCL_HIGH_CYC  = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          BUS_FREE_CYC  = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          TMR_BITS      = 10;         // Timer width, holds every count above.

   // ****************************************************************
   // Reset values.
   // ****************************************************************
   localparam logic [3:0]  BIT_CNT_RST = 4'h0;         // Bit counter after reset.
   localparam logic [7:0]  BYTE_RST    = 8'h00;        // Shift registers after reset.

endpackage

/* File: iwt_bus_if.sv */
`timescale 1ns/1ps
// ****************************************************************
// Two-wire bus between controller and target, open drain with pull-ups.
// ****************************************************************
interface iwt_bus_if;
   logic ctl_scl_o;     // Controller clock drive value.
   logic ctl_scl_oe_n;  // Controller clock enable, low drives.
   logic ctl_sda_o;     // Controller data drive value.
   logic ctl_sda_oe_n;  // Controller data enable, low drives.
   logic tgt_sda_o;     // Target data drive value.
   logic tgt_sda_oe_n;  // Target data enable, low drives.
   logic scl;           // Resolved clock line.
   logic sda;           // Resolved data line.

   // A released line floats high through the pull-up; any driver wins low.
   assign scl = ctl_scl_oe_n | ctl_scl_o;
   assign sda = (ctl_sda_oe_n | ctl_sda_o) & (tgt_sda_oe_n | tgt_sda_o);

   modport controller (input scl, input sda, output ctl_scl_o, output ctl_scl_oe_n,
                       output ctl_sda_o, output ctl_sda_oe_n);
   modport target (input scl, input sda, output tgt_sda_o, output tgt_sda_oe_n);
endinterface

/* File: iwt_controller.sv */
`timescale 1ns/1ps
// ****************************************************************
// Bus controller: writes user bytes to the target in one access.
// ****************************************************************
module iwt_controller #(
   parameter logic [6:0] ADDR = iwt_pkg::TARGET_ADDR      // Target address to call.
) (
   input  wire logic       clk,        // 100 MHz local clock.
   input  wire logic       rst_n,      // Asynchronous reset, active low.
   iwt_bus_if.controller   bus,        // Two-wire bus.
   input  wire logic [7:0] cmd_data,   // Byte to write.
   input  wire logic       cmd_last,   // Byte ends the access.
   input  wire logic       cmd_valid,  // Byte offered.
   output logic            cmd_ready,  // Byte taken this cycle.
   output logic            busy,       // Access in progress.
   output logic            nack        // One-cycle pulse: acknowledge missing.
);
   typedef enum logic [2:0] {
      ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_NEXT, ST_STOP_LOW, ST_STOP_HIGH, ST_FREE
   } iwt_cstate_t;

   localparam logic [iwt_pkg::TMR_BITS-1:0] LOW_T  = iwt_pkg::TMR_BITS'(iwt_pkg::SCL_LOW_CYC-1);
   localparam logic [iwt_pkg::TMR_BITS-1:0] HIGH_T = iwt_pkg::TMR_BITS'(iwt_pkg::SCL_HIGH_CYC-1);
   localparam logic [iwt_pkg::TMR_BITS-1:0] FREE_T = iwt_pkg::TMR_BITS'(iwt_pkg::BUS_FREE_CYC-1);

   iwt_cstate_t                 state;     // Bus sequencer state.
   logic [iwt_pkg::TMR_BITS-1:0] tmr;      // Cycles left in this phase.
   logic [3:0]                  bit_idx;   // Pulse within the byte, 0 to 8.
   logic [7:0]                  shreg;     // Byte going out, MSB first.
   logic [7:0]                  pend;      // First data byte, held behind the address.
   logic                        pend_last; // The held byte ends the access.
   logic                        last;      // Byte in flight ends the access.
   logic                        in_addr;   // Byte in flight is the address.
   logic                        sda_meta;  // Data synchroniser, first stage.
   logic                        sda_sync;  // Data synchroniser, second stage.

   wire tmr_done = tmr == '0;
   wire take     = cmd_valid && cmd_ready;
   wire ack_slot = bit_idx == 4'(iwt_pkg::ACK_BIT_IDX);
   wire got_ack  = !sda_sync;
   wire end_now  = !got_ack || (!in_addr && last);

   // The data line is read back through two flops before use.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {sda_meta, sda_sync} <= 2'b11;
      end else begin
         {sda_meta, sda_sync} <= {bus.sda, sda_meta};
      end
   end

   // ****************************************************************
   // Sequencer: each phase lasts its least legal time, save the clock low stretched in ST_NEXT.
   // ****************************************************************
   // The clock is divided from the local clock, so this end owns the bus timing.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state            <= ST_IDLE;
         tmr              <= '0;
         bit_idx          <= iwt_pkg::BIT_CNT_RST;
         shreg            <= iwt_pkg::BYTE_RST;
         pend             <= iwt_pkg::BYTE_RST;
         {pend_last, last, in_addr} <= 3'b000;
         bus.ctl_scl_oe_n <= 1'b1;
         bus.ctl_sda_oe_n <= 1'b1;
         bus.ctl_scl_o    <= 1'b0;
         bus.ctl_sda_o    <= 1'b0;
         cmd_ready        <= 1'b0;
         busy             <= 1'b0;
         nack             <= 1'b0;
      end else begin
         nack      <= 1'b0;
         cmd_ready <= 1'b0;
         if (tmr != '0) begin
            tmr <= tmr - 1'b1;
         end
         unique case (state)
            ST_IDLE: begin
               busy      <= 1'b0;
               cmd_ready <= !take;
               if (take) begin
                  // Data falls with the clock high: start.
                  pend             <= cmd_data;
                  pend_last        <= cmd_last;
                  busy             <= 1'b1;
                  bus.ctl_sda_oe_n <= 1'b0;
                  tmr              <= HIGH_T;
                  state            <= ST_START;
               end
            end
            ST_START: begin
               if (tmr_done) begin
                  bus.ctl_scl_oe_n <= 1'b0;
                  shreg            <= {ADDR, iwt_pkg::DIR_WRITE};
                  in_addr          <= 1'b1;
                  bit_idx          <= 4'h0;
                  tmr              <= LOW_T;
                  state            <= ST_LOW;
               end
            end
            ST_LOW: begin
               // Data changes only while the clock is low.
               bus.ctl_sda_oe_n <= ack_slot ? 1'b1 : shreg[7];
               if (tmr_done) begin
                  bus.ctl_scl_oe_n <= 1'b1;
                  tmr              <= HIGH_T;
                  state            <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (tmr_done) begin
                  bus.ctl_scl_oe_n <= 1'b0;
                  tmr              <= LOW_T;
                  if (!ack_slot) begin
                     shreg   <= {shreg[6:0], 1'b0};
                     bit_idx <= bit_idx + 4'h1;
                     state   <= ST_LOW;
                  end else if (end_now) begin
                     nack  <= !got_ack;
                     state <= ST_STOP_LOW;
                  end else if (in_addr) begin
                     shreg   <= pend;
                     last    <= pend_last;
                     in_addr <= 1'b0;
                     bit_idx <= 4'h0;
                     state   <= ST_LOW;
                  end else begin
                     cmd_ready <= 1'b1;
                     state     <= ST_NEXT;
                  end
               end
            end
            ST_NEXT: begin
               // The clock stays low until the user offers the next byte.
               bus.ctl_sda_oe_n <= 1'b1;
               cmd_ready        <= !take;
               if (take) begin
                  shreg   <= cmd_data;
                  last    <= cmd_last;
                  bit_idx <= 4'h0;
                  tmr     <= LOW_T;
                  state   <= ST_LOW;
               end
            end
            ST_STOP_LOW: begin
               bus.ctl_sda_oe_n <= 1'b0;
               if (tmr_done) begin
                  bus.ctl_scl_oe_n <= 1'b1;
                  tmr              <= HIGH_T;
                  state            <= ST_STOP_HIGH;
               end
            end
            ST_STOP_HIGH: begin
               if (tmr_done) begin
                  bus.ctl_sda_oe_n <= 1'b1;
                  tmr              <= FREE_T;
                  state            <= ST_FREE;
               end
            end
            ST_FREE: begin
               if (tmr_done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end
endmodule // iwt_controller

/* File: iwt_bus_assertions.sv */
`timescale 1ns/1ps
// ********
// Bus watcher. Flags: in frame, first byte, refused.
// ********
module iwt_bus_assertions (
   input wire logic clk,         // Local clock.
   input wire logic rst_n,       // Reset, active low.
   input wire logic scl,         // Clock line.
   input wire logic sda,         // Data line.
   input wire logic tgt_sda_oe_n // Target pulls data when low.
);
   logic [2:0] f;    // In frame, first byte, refused.
   logic [3:0] bcnt; // Clock rises seen in this byte.
   logic [7:0] sh;   // Byte so far, first bit on top.
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Start beats stop, as on the target; the ninth rise closes a byte.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         f    <= 3'h0;
         bcnt <= 4'h0;
         sh   <= 8'h00;
      end else if (scl && $fell(sda)) begin
         f    <= 3'h6;
         bcnt <= 4'h0;
      end else if (scl && $rose(sda)) begin
         f[2] <= 1'b0;
      end else if ($rose(scl) && bcnt == 4'h8) begin
         bcnt   <= 4'h0;
         f[1:0] <= {1'b0, f[0] | (f[1] && sh != {iwt_pkg::TARGET_ADDR, iwt_pkg::DIR_WRITE})};
      end else if ($rose(scl)) begin
         bcnt <= bcnt + 4'h1;
         sh   <= {sh[6:0], sda};
      end
   end
   sequence s_ack_low; !tgt_sda_oe_n && scl; endsequence
   property p_idle; !f[2] |-> tgt_sda_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("target pulls idle bus");
   property p_stable; scl && $past(scl) |-> $stable(tgt_sda_oe_n); endproperty
   a_stable: assert property (p_stable) else $error("data moved, clock high");
   property p_slot; $fell(tgt_sda_oe_n) |-> bcnt == 4'h8 && !scl; endproperty
   a_slot: assert property (p_slot) else $error("ack out of slot");
   property p_hold; $rose(scl) && !tgt_sda_oe_n |-> s_ack_low [*8]; endproperty
   a_hold: assert property (p_hold) else $error("ack not held");
   property p_release; $fell(scl) && !tgt_sda_oe_n |-> ##[1:8] tgt_sda_oe_n; endproperty
   a_release: assert property (p_release) else $error("ack not released");
   property p_addr; $fell(tgt_sda_oe_n) && f[1] |->
      sh == {iwt_pkg::TARGET_ADDR, iwt_pkg::DIR_WRITE}; endproperty
   a_addr: assert property (p_addr) else $error("ack to wrong address");
   property p_ignore; f[0] |-> tgt_sda_oe_n; endproperty
   a_ignore: assert property (p_ignore) else $error("refused target pulls");
   property p_stop; scl && $rose(sda) |=> tgt_sda_oe_n [*8]; endproperty
   a_stop: assert property (p_stop) else $error("target pulls after stop");
endmodule // iwt_bus_assertions

/* File: iwt_target_bench.sv */
`timescale 1ns/1ps
// ********
// Two pairs: one calls the target, one calls a wrong address.
// ********
module iwt_target_bench;
   logic       clk = 1'b0;        // Local clock.
   logic       rst_n = 1'b0;      // Reset, active low.
   logic [7:0] cmd_data = 8'h00;  // Byte offered to both callers.
   logic       cmd_last = 1'b0;   // Byte ends the access.
   logic       cmd_valid = 1'b0;  // Offer to the first caller.
   logic       cmd2_valid = 1'b0; // Offer to the wrong caller.
   logic       code_ready = 1'b0; // Drain, stalls at random.
   logic       cmd_ready, busy, nack, cmd2_ready, busy2, nack2;
   logic       code_valid, code_valid2, selected, selected2;
   logic [6:0] code, code2;
   logic [6:0] exp_q[$];          // Codes still owed.
   int         bad_count = 0;     // Mismatches.
   int         tests_run = 0;     // Comparisons.
   iwt_bus_if  bus ();            // Bus under test.
   iwt_bus_if  bus2 ();           // Bus to a wrong address.
   always #5 clk = ~clk;
   iwt_controller iwt_controller_i (.clk, .rst_n, .bus, .cmd_data, .cmd_last, .cmd_valid,
      .cmd_ready, .busy, .nack);
   iwt_target iwt_target_i (.clk, .rst_n, .bus, .code, .code_valid, .code_ready, .selected);
   iwt_controller #(.ADDR(7'h74)) iwt_controller_i2 (.clk, .rst_n, .bus(bus2), .cmd_data,
      .cmd_last, .cmd_valid(cmd2_valid), .cmd_ready(cmd2_ready), .busy(busy2), .nack(nack2));
   iwt_target iwt_target_i2 (.clk, .rst_n, .bus(bus2), .code(code2), .code_valid(code_valid2),
      .code_ready, .selected(selected2));
   iwt_bus_assertions iwt_bus_assertions_i (.clk, .rst_n, .scl(bus.scl), .sda(bus.sda),
      .tgt_sda_oe_n(bus.tgt_sda_oe_n));
   task automatic cmp_code(input logic [6:0] got, input logic [6:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t code %h, expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_flag(input logic got, input logic exp, input string what);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask
   // A wait that runs out is a mismatch and ends the run at once.
   task automatic check_limit(input int n);
      if (n >= 30000) begin
         bad_count++;
         $display("[FAIL] %0t wait ran out", $time);
         tally_and_finish();
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Offer one byte and hold it until taken; a code the target owes is noted.
   task automatic send(input logic [7:0] d, input logic last, input logic alt);
      int n;
      n = 0;
      @(posedge clk);
      #1;
      cmd_data = d;
      cmd_last = last;
      if (alt) cmd2_valid = 1'b1;
      else cmd_valid = 1'b1;
      do @(posedge clk); while ((alt ? cmd2_ready : cmd_ready) !== 1'b1 && ++n < 30000);
      check_limit(n);
      #1;
      cmd_valid = 1'b0;
      cmd2_valid = 1'b0;
      if (!alt && !d[7]) exp_q.push_back(d[6:0]);
   endtask
   // Wait out the stop and the bus-free gap, then both lines must rest high.
   task automatic finish_access(input int t);
      int n;
      n = 0;
      while ((busy | busy2) !== 1'b0 && ++n < 30000) @(posedge clk);
      check_limit(n);
      cmp_flag(bus.scl & bus.sda & bus2.scl & bus2.sda, 1'b1, "bus not idle");
      cmp_flag(selected, 1'b0, "still selected");
      $display("test %0d done", t);
   endtask
   // Watcher: codes in order; the refused side must stay silent.
   always @(posedge clk) begin
      if (rst_n === 1'b1 && code_valid === 1'b1 && code_ready === 1'b1) begin
         if (exp_q.size() == 0) cmp_flag(1'b1, 1'b0, "extra code");
         else cmp_code(code, exp_q.pop_front());
      end
      if (rst_n === 1'b1 && (nack | code_valid2 | selected2 | ~bus2.tgt_sda_oe_n) !== 1'b0)
         cmp_flag(1'b1, 1'b0, "refusal broken");
   end
   // Watchdog: the tests take some 60000 cycles.
   initial begin
      #800000;
      bad_count++;
      $display("[FAIL] %0t watchdog ran out", $time);
      tally_and_finish();
   end
   initial begin
      int n;
      n = 0;
      void'($urandom(23));
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'b1;
      fork
         forever begin
            @(posedge clk);
            #1;
            code_ready = 1'($urandom_range(1));
         end
      join_none
      // Test 1: three bytes in one access, the middle one gated off.
      send({1'b0, 7'($urandom)}, 1'b0, 1'b0);
      send({1'b1, 7'($urandom)}, 1'b0, 1'b0);
      cmp_flag(selected, 1'b1, "not selected");
      send(8'($urandom), 1'b1, 1'b0);
      finish_access(1);
      // Test 2: a fresh access with the top code.
      send(8'h7F, 1'b1, 1'b0);
      finish_access(2);
      // Test 3: an address one bit off is refused.
      send(8'h05, 1'b1, 1'b1);
      while (nack2 !== 1'b1 && ++n < 30000) @(posedge clk);
      cmp_flag(nack2, 1'b1, "no refusal");
      finish_access(3);
      cmp_flag(exp_q.size() == 0, 1'b1, "codes missing");
      tally_and_finish();
   end
endmodule // iwt_target_bench
